// [bench/lfsr_crc_prs_block_sva.sv]
// Purpose: Bus and read-back checks on the LFSR checksum block
// Assumes: Single clock, sync active-low reset
// Notes:   Enable is internal, so aux_out is judged by the bench
`include "lfsr_crc_prs_defines.vh"
module lfsr_crc_prs_block_sva (
   input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
   input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic [4:0]  s_axi_awaddr, s_axi_araddr,
   input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   wire logic rd_go = s_axi_arvalid & s_axi_arready;
   a_read_answer: assert property (rd_go |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   a_write_answer: assert property (wr_go |=> s_axi_bvalid)
      else $error("write answer missing");
   a_state_reads_zero: assert property (rd_go && s_axi_araddr == `ADDR_LFSR_STATE
      |=> s_axi_rdata == 32'h0 && s_axi_rresp == `RESP_OKAY) else $error("state read not zero");
   a_poly_write_only: assert property (rd_go && s_axi_araddr == `ADDR_FEEDBACK_POLY
      |=> s_axi_rdata == 32'h0) else $error("polynomial readable");
   a_state_not_writable: assert property (wr_go && s_axi_awaddr == `ADDR_LFSR_STATE
      |=> s_axi_bresp == `RESP_SLVERR) else $error("state write accepted");
   a_upper_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_seed_readable: assert property (rd_go && s_axi_araddr == `ADDR_SEED_RESIDUE
      |=> s_axi_rresp == `RESP_OKAY) else $error("seed read refused");
   a_unmapped_error: assert property (rd_go && s_axi_araddr > 5'h10
      |=> s_axi_rresp == `RESP_SLVERR) else $error("unmapped read accepted");
endmodule // lfsr_crc_prs_block_sva

bind lfsr_crc_prs_block lfsr_crc_prs_block_sva i_lfsr_crc_prs_block_sva (.*);

// [bench/lfsr_crc_prs_block_tb.sv]
// Purpose: Register-level tests of the LFSR checksum block
// Assumes: AXI4-Lite master tasks, reference LFSR kept beside the bus
// Notes:   State 0 with data_in low stays 0, which pins the compare tests
`include "lfsr_crc_prs_defines.vh"
module lfsr_crc_prs_block_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, data_in = 0, en;
   logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [7:0]  st, poly;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, aux_out;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   int          n_fail = 0, checked = 0;
   lfsr_crc_prs_block i_lfsr_crc_prs_block (.*);
   // ----------------------------------------
   // Reference state, tracked at write execution
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         en <= 0; st <= 8'h00; poly <= 8'h00;
      end else begin
         if (en) st <= {st[6:0], 1'b0} ^ (poly & {8{st[7] ^ data_in}});
         if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
            if (s_axi_awaddr == `ADDR_CONTROL) en <= s_axi_wdata[0];
            if (s_axi_awaddr == `ADDR_FEEDBACK_POLY) poly <= s_axi_wdata[7:0];
            if (s_axi_awaddr == `ADDR_SEED_RESIDUE && !en) st <= s_axi_wdata[7:0];
         end
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   task wr(input [4:0] a, input [31:0] d, input [1:0] r = `RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(s_axi_bresp, r);
   endtask
   task rd(input [4:0] a, input [31:0] e, input [1:0] r = `RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask
   task results;
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial forever #5 aclk = ~aclk;
   // Whole run is under two hundred cycles
   initial begin
      #20000;
      n_fail++;
      results;
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rd(`ADDR_SEED_RESIDUE, 0);
      wr(`ADDR_FEEDBACK_POLY, 32'h1D);
      rd(`ADDR_FEEDBACK_POLY, 0);
      wr(`ADDR_LFSR_STATE, 32'h77, `RESP_SLVERR);
      rd(5'h14, 0, `RESP_SLVERR);
      wr(`ADDR_SEED_RESIDUE, 32'h5A);
      rd(`ADDR_LFSR_STATE, 0);
      rd(`ADDR_SEED_RESIDUE, 32'h5A);
      data_in <= 1;
      wr(`ADDR_CONTROL, 1);
      repeat (13) @(posedge aclk);
      data_in <= 0;
      repeat (5) @(posedge aclk);
      wr(`ADDR_CONTROL, 0);
      rd(`ADDR_LFSR_STATE, 0);
      rd(`ADDR_SEED_RESIDUE, {24'h0, st});
      wr(`ADDR_SEED_RESIDUE, 0);
      wr(`ADDR_CONTROL, 1);
      for (int m = 0; m < 4; m++) begin
         for (int x = 0; x < 10; x += 5) begin
            wr(`ADDR_FUNCTION, m);
            wr(`ADDR_SEED_RESIDUE, x);
            repeat (2) @(posedge aclk);
            chk(aux_out, m == 1 || (m == 0 ? x == 0 : x != 0));
         end
      end
      wr(`ADDR_CONTROL, 0);
      repeat (2) @(posedge aclk);
      chk(aux_out, 0);
      results;
   end
endmodule // lfsr_crc_prs_block_tb

// [hw/lfsr_crc_prs_block.v]
// Purpose: LFSR based checksum checker / pseudo-random sequence generator
// Assumes: AXI4-Lite slave, single clock, synchronous active-low reset
// Assumes: Registers sit in byte lane 0 of each aligned word
// Notes:   Serial input data_in feeds the LFSR in checksum use; tie low for PRS
// Notes:   aux_out is registered and lags the compared values by one clock
// Notes:   Software keeps state reads and polynomial writes to disabled times
// Notes:   Galois form keeps the step to one xor level per bit
// Notes:   Unmapped offsets answer with an error response
// Notes:   A write with the lane 0 strobe low is a quiet no-op
//
// Summary of operation
// [RULE1] Three 8-bit data registers plus a 2-bit control register.
// [RULE2] While enabled, state register holds LFSR state, updated on block clock.
// [RULE3] Disabled: writing seed/residue also loads the same value into state.
// [RULE4] Disabled: reading state returns 00h and copies state into seed/residue.
// [RULE5] Software does not read the state register while enabled.
// [RULE6] Polynomial register is write-only and sets feedback taps for both uses.
// [RULE7] Software writes the polynomial only while disabled.
// [RULE8] Seed/residue is read-write; enabled writes become the compare operand.
// [RULE9] Enabled: compare state against seed/residue by mode, drive aux output.
// [RULE10] Residue retrieval: disable, read state, then read seed/residue.
// [RULE11] Disabled holds the state; enabled advances one step per clock.
//
// Local design decisions: the AXI4-Lite register port and the address map.

module lfsr_crc_prs_block #(
   parameter WIDTH = 8
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        data_in,
   output reg         aux_out
);

`include "lfsr_crc_prs_defines.vh"

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Map, byte addresses, data right-aligned:
   //   0x00  lfsr_state              reads 00h, disabled read copies into seed
   //   0x04  feedback_polynomial     write only, reads 00h
   //   0x08  seed_and_residue        read-write, disabled write loads state
   //   0x0C  control                 bit 0 enable, bit 1 spare
   //   0x10  lfsr_checksum_function  compare mode
   // Modes: 0 equal, 1 state <= seed, 2 state < seed, 3 not equal
   // Writes to the state offset answer with an error and change nothing
   // A state read while enabled leaves the seed register untouched,
   // so a residue is only captured after disabling

   reg  [WIDTH-1:0]           lfsr_state;            // [RULE1]
   reg  [WIDTH-1:0]           feedback_polynomial;
   reg  [WIDTH-1:0]           seed_and_residue;
   reg  [`CTRL_WIDTH-1:0]     control;
   reg  [`MODE_WIDTH-1:0]     lfsr_checksum_function;

   reg                        aw_held;
   reg  [4:0]                 aw_addr;
   reg                        w_held;
   reg  [31:0]                w_data;
   reg  [3:0]                 w_strb;

   wire enable = control[`CTRL_ENABLE_BIT];

   // ----------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ----------------------------------------------------------------
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

   wire       aw_take = s_axi_awvalid & s_axi_awready;
   wire       w_take  = s_axi_wvalid & s_axi_wready;
   wire       have_aw = aw_held | aw_take;
   wire       have_w  = w_held | w_take;
   wire       do_write = have_aw & have_w;
   wire [4:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   // Registers live in byte lane 0 only
   wire       wr_lane0 = wr_strb[`STRB_LANE0];

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   wire wr_state = do_write && wr_addr == `ADDR_LFSR_STATE;
   wire wr_poly  = do_write && wr_addr == `ADDR_FEEDBACK_POLY;
   wire wr_seed  = do_write && wr_addr == `ADDR_SEED_RESIDUE;
   wire wr_ctrl  = do_write && wr_addr == `ADDR_CONTROL;
   wire wr_func  = do_write && wr_addr == `ADDR_FUNCTION;
   wire wr_known = wr_state | wr_poly | wr_seed | wr_ctrl | wr_func;

   // Halves wait here until their partner arrives
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 5'h00;
         w_held  <= 1'b0;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else if (do_write) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // ----------------------------------------------------------------
   // Write response: one answer per executed write
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         // State register is not writable; it and unmapped addresses error
         s_axi_bresp  <= (wr_known & ~wr_state) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read channel: one-cycle answer after address accepted
   // ----------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;
   wire rd_take  = s_axi_arvalid & s_axi_arready;
   wire rd_state = rd_take && s_axi_araddr == `ADDR_LFSR_STATE;

   // Read data decoded from the address while it is offered
   reg  [31:0]                next_rdata;
   reg  [1:0]                 next_rresp;

   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `RESP_OKAY;
      case (s_axi_araddr)
         `ADDR_LFSR_STATE: begin
            next_rdata = {24'h000000, `READ_ZERO};                      // [RULE4]
         end
         `ADDR_FEEDBACK_POLY: begin
            next_rdata = {24'h000000, `READ_ZERO};                      // [RULE6]
         end
         `ADDR_SEED_RESIDUE: begin
            next_rdata = {24'h000000, seed_and_residue};                // [RULE8]
         end
         `ADDR_CONTROL: begin
            next_rdata = {30'h0, control};
         end
         `ADDR_FUNCTION: begin
            next_rdata = {30'h0, lfsr_checksum_function};
         end
         default: begin
            next_rresp = `RESP_SLVERR;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // LFSR step: Galois form, taps from the polynomial register
   // ----------------------------------------------------------------
   // Feedback = msb xor serial input; with data_in low this is a plain PRS
   // A zero state with data_in low never leaves zero, whatever the taps
   wire             feedback = lfsr_state[WIDTH-1] ^ data_in;
   wire [WIDTH-1:0] shifted;
   wire [WIDTH-1:0] stepped_lfsr;

   assign shifted[0] = 1'b0;

   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < WIDTH; bit_idx = bit_idx + 1) begin : g_step
         if (bit_idx > 0) begin : g_shift
            assign shifted[bit_idx] = lfsr_state[bit_idx-1];
         end
         assign stepped_lfsr[bit_idx] = shifted[bit_idx]
                                        ^ (feedback_polynomial[bit_idx] & feedback); // [RULE6]
      end
   endgenerate

   // ----------------------------------------------------------------
   // Register next values
   // ----------------------------------------------------------------
   reg  [WIDTH-1:0]           next_lfsr_state;
   reg  [WIDTH-1:0]           next_feedback_polynomial;
   reg  [WIDTH-1:0]           next_seed_and_residue;
   reg  [`CTRL_WIDTH-1:0]     next_control;
   reg  [`MODE_WIDTH-1:0]     next_lfsr_checksum_function;

   always @* begin
      next_lfsr_state             = lfsr_state;
      next_feedback_polynomial    = feedback_polynomial;
      next_seed_and_residue       = seed_and_residue;
      next_control                = control;
      next_lfsr_checksum_function = lfsr_checksum_function;
      if (enable) begin
         next_lfsr_state = stepped_lfsr;                                 // [RULE2] [RULE11]
      end else if (wr_seed && wr_lane0) begin
         next_lfsr_state = wr_data[WIDTH-1:0];                           // [RULE3]
      end
      // Polynomial written while enabled is still taken; software avoids it
      if (wr_poly && wr_lane0) begin
         next_feedback_polynomial = wr_data[WIDTH-1:0];                  // [RULE6]
      end
      // A seed write and a state read in one cycle: the write wins
      if (wr_seed && wr_lane0) begin
         next_seed_and_residue = wr_data[WIDTH-1:0];                     // [RULE8]
      end else if (rd_state && !enable) begin
         next_seed_and_residue = lfsr_state;                             // [RULE4]
      end
      if (wr_ctrl && wr_lane0) begin
         next_control = wr_data[`CTRL_WIDTH-1:0];
      end
      if (wr_func && wr_lane0) begin
         next_lfsr_checksum_function = wr_data[`MODE_WIDTH-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Register update
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         lfsr_state             <= `LFSR_RESET;
         feedback_polynomial    <= `POLY_RESET;
         seed_and_residue       <= `SEED_RESET;
         control                <= {`CTRL_WIDTH{1'b0}};
         lfsr_checksum_function <= `MODE_EQUAL;
      end else begin
         lfsr_state             <= next_lfsr_state;
         feedback_polynomial    <= next_feedback_polynomial;
         seed_and_residue       <= next_seed_and_residue;
         control                <= next_control;
         lfsr_checksum_function <= next_lfsr_checksum_function;
      end
   end

   // ----------------------------------------------------------------
   // Compare output
   // ----------------------------------------------------------------
   // All four mode codes are decoded; the default only guards unknowns
   reg compare_hit;
   always @* begin
      case (lfsr_checksum_function)
         `MODE_EQUAL:         compare_hit = lfsr_state == seed_and_residue;
         `MODE_LESS_OR_EQUAL: compare_hit = lfsr_state <= seed_and_residue;
         `MODE_LESS:          compare_hit = lfsr_state <  seed_and_residue;
         `MODE_NOT_EQUAL:     compare_hit = lfsr_state != seed_and_residue;
         default:             compare_hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Auxiliary output
   // ----------------------------------------------------------------
   // Registered so the pin never glitches; costs one clock of lag
   // Forced low while disabled so a stale compare never shows
   always @(posedge aclk) begin
      if (!aresetn)
         aux_out <= 1'b0;
      else
         aux_out <= enable & compare_hit;                                // [RULE9]
   end

endmodule // lfsr_crc_prs_block

// [hw/lfsr_crc_prs_defines.vh]
// Purpose: Constants for the LFSR checksum / pseudo-random block
// Assumes: 32-bit AXI4-Lite register window, 8-bit data registers
// Notes:   Offsets are byte addresses
`ifndef LFSR_CRC_PRS_DEFINES_VH
`define LFSR_CRC_PRS_DEFINES_VH

`define ADDR_LFSR_STATE        5'h00
`define ADDR_FEEDBACK_POLY     5'h04
`define ADDR_SEED_RESIDUE      5'h08
`define ADDR_CONTROL           5'h0C
`define ADDR_FUNCTION          5'h10
`define STRB_LANE0             0

`define CTRL_ENABLE_BIT        0
`define CTRL_WIDTH             2
`define MODE_WIDTH             2

`define MODE_EQUAL             2'h0
`define MODE_LESS_OR_EQUAL     2'h1
`define MODE_LESS              2'h2
`define MODE_NOT_EQUAL         2'h3

`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`define LFSR_RESET             8'h00
`define POLY_RESET             8'h00
`define SEED_RESET             8'h00
`define READ_ZERO              8'h00

`endif
